/* File: design/sdb_burst_engine.sv */
// Function
// [R1] Read carries bank, column, auto-precharge; row closed when burst ends.
// [R2] First read word after CAS latency, one more word each edge.
// [R3] Burst done with no command: data pins float; full page wraps to 0.
// [R4] Controller chains reads latency-minus-one before last wanted word.
// [R5] A new read is accepted on any clock, any bank.
// [R6] Controller leaves turnaround room before a write after a read.
// [R7] Mask high three clocks ahead; output mask acts two clocks later.
// [R8] Truncating write floats pins; invalid unless mask was high before.
// [R9] Write data mask acts with zero latency.
// [R10] Precharge to same bank ends read latency-minus-one before last word.
// [R11] Burst terminate ends read latency-minus-one before last word.
// [R12] Write word captured with the command, then one per edge.
// [R13] Fixed write done: further input ignored; full page wraps to 0.
// [R14] New write on any clock truncates earlier write, takes its data.
// [R15] Read registered during write stops write data capture.
// [R16] Controller waits write recovery before precharge after write.
// [R17] Controller masks data before and at a write-truncating precharge.
// [R18] Controller waits row precharge time after precharge.
// [R19] Terminate ends write; data with the terminate is ignored.
// [R20] Unused column bits dropped per organisation.
// [R21] Read at n, latency m: drive after n+m-1, valid at n+m.
// [R22] Burst order by length, start column and sequential or interleaved type.
// [R23] Controller tracks open rows and sends idle cycles otherwise.
`timescale 1ns/1ps
module sdb_burst_engine #(
  parameter int DATA_W = 32
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      cs_n_i,
  input  wire logic                      ras_n_i,
  input  wire logic                      cas_n_i,
  input  wire logic                      we_n_i,
  input  wire logic [1:0]                bank_select_i,
  input  wire logic [12:0]               addr_i,
  input  wire logic                      dqm_i,
  input  wire logic [DATA_W-1:0]         dq_i,
  output logic      [DATA_W-1:0]         dq_o,
  output logic                           dq_oe_o,
  output logic      [14:0]               mem_addr_o,
  output logic                           mem_rd_o,
  output logic                           mem_we_o,
  output logic      [DATA_W-1:0]         mem_wdata_o,
  input  wire logic [DATA_W-1:0]         mem_rdata_i,
  output logic                           bank_close_o,
  output logic      [1:0]                close_bank_o,
  input  wire logic [1:0]                reg_addr_i,
  input  wire logic [15:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [15:0]               reg_rdata_o
);

  if (DATA_W < 8 || DATA_W > 64) begin : g_chk
    $error("sdb_burst_engine: DATA_W must lie in 8..64");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0]       mode;
    logic              act;
    logic              wdir;
    logic              ap;
    logic [1:0]        bank;
    logic [2:0]        lcode;
    logic [10:0]       start;
    logic [10:0]       idx;
    logic [14:0]       maddr;
    logic              mrd;
    logic              mwe;
    logic [DATA_W-1:0] mwd;
    logic              p1_v;
    logic [DATA_W-1:0] p1_d;
    logic [DATA_W-1:0] dq;
    logic              dq_oe;
    logic              dqm_d1;
    logic              cls;
    logic [1:0]        cls_bank;
    logic [15:0]       rdata;
    logic [15:0]       wcnt;
    logic [15:0]       icnt;
  } sdb_state_t;

  sdb_state_t st_reg;
  sdb_state_t st_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] col_of(input logic [12:0] a, input logic [1:0] org);
    case (org)
      sdb_pkg::ORG_X32: col_of = {2'h0, a[8:0]};
      sdb_pkg::ORG_X16: col_of = {1'h0, a[9:0]};
      default:          col_of = {a[11], a[9:0]};
    endcase
  endfunction

  function automatic logic [10:0] page_of(input logic [1:0] org);
    case (org)
      sdb_pkg::ORG_X32: page_of = sdb_pkg::PAGE_X32;
      sdb_pkg::ORG_X16: page_of = sdb_pkg::PAGE_X16;
      default:          page_of = sdb_pkg::PAGE_X8;
    endcase
  endfunction

  function automatic logic fixed_len(input logic [2:0] code);
    fixed_len = (code <= sdb_pkg::LEN_MAX_FIXED);
  endfunction

  logic [3:0]  cmd;
  logic        is_rd;
  logic        is_wr;
  logic        is_bst;
  logic        is_pre;
  logic        cl3;
  logic [1:0]  org;
  logic [2:0]  rd_code;
  logic [2:0]  wr_code;
  logic [10:0] cmd_col;
  logic [10:0] blk;
  logic [10:0] col_nxt;
  logic        last;
  logic        kill;
  logic        src_v;
  logic        pend;

  assign cmd     = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  assign is_rd   = (cmd == sdb_pkg::CMD_READ);
  assign is_wr   = (cmd == sdb_pkg::CMD_WRITE);
  assign is_bst  = (cmd == sdb_pkg::CMD_BST);
  assign is_pre  = (cmd == sdb_pkg::CMD_PRE);
  assign cl3     = (st_reg.mode[sdb_pkg::M_CL_LSB +: 3] == sdb_pkg::CL_THREE);
  assign org     = st_reg.mode[sdb_pkg::M_ORG_LSB +: 2];
  assign rd_code = st_reg.mode[sdb_pkg::M_LEN_LSB +: 3];
  // Single-location writes use the burst-of-one code
  assign wr_code = st_reg.mode[sdb_pkg::M_WSGL_BIT] ? 3'h0 : rd_code;
  assign cmd_col = col_of(addr_i, org); // [R20]

  // Full page wraps across the whole page, fixed bursts inside their block
  assign blk = fixed_len(st_reg.lcode) ?
               11'((11'h1 << st_reg.lcode) - 11'h1) : page_of(org); // [R22] [R3] [R13]

  sdb_col_gen #(
    .COL_W (11)
  ) u_col_gen (
    .start_i (st_reg.start),
    .idx_i   (st_reg.idx),
    .blk_i   (blk),
    .il_i    (st_reg.mode[sdb_pkg::M_TYPE_BIT] & fixed_len(st_reg.lcode)),
    .col_o   (col_nxt)
  );

  assign last = fixed_len(st_reg.lcode) &&
                (st_reg.idx == 11'((11'h1 << st_reg.lcode) - 11'h1));
  // Terminate, precharge to this bank or all banks, or any new access ends a burst
  assign kill = is_rd | is_wr | is_bst |
                (is_pre & (addr_i[sdb_pkg::AP_BIT] | (bank_select_i == st_reg.bank)));
  // Read output still on its way to the pins
  assign pend = st_reg.mrd | st_reg.p1_v | st_reg.dq_oe;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.mrd    = 1'b0;
    st_next.mwe    = 1'b0;
    st_next.cls    = 1'b0;
    st_next.rdata  = 16'h0000;
    st_next.dqm_d1 = dqm_i;

    // Output path: one extra stage for latency three
    st_next.p1_v  = st_reg.mrd;
    st_next.p1_d  = mem_rdata_i;
    src_v         = cl3 ? st_reg.p1_v : st_reg.mrd; // [R2] [R21]
    st_next.dq    = cl3 ? st_reg.p1_d : mem_rdata_i;
    // Mask taken at the previous edge gives the two-clock output latency
    st_next.dq_oe = src_v & ~st_reg.dqm_d1; // [R7] [R3]

    // Running burst, one column per edge
    if (st_reg.act) begin
      st_next.maddr = {st_reg.bank, col_nxt};
      st_next.idx   = st_reg.idx + 11'h001;
      if (st_reg.wdir) begin
        st_next.mwe = ~dqm_i; // [R12] [R9]
        st_next.mwd = dq_i;
      end else begin
        st_next.mrd = 1'b1; // [R2]
      end
      if (last) begin
        st_next.act      = 1'b0; // [R13]
        st_next.cls      = st_reg.ap; // [R1]
        st_next.cls_bank = st_reg.bank;
      end
    end

    // Truncation: the word of this edge is neither issued nor written
    if (kill && st_reg.act) begin
      st_next.act      = 1'b0; // [R10] [R11] [R15] [R19]
      st_next.mrd      = 1'b0;
      st_next.mwe      = 1'b0; // [R15] [R19]
      st_next.cls      = st_reg.ap;
      st_next.cls_bank = st_reg.bank;
    end

    if (is_rd) begin
      st_next.maddr = {bank_select_i, cmd_col}; // [R1] [R5]
      st_next.mrd   = 1'b1;
      st_next.act   = (rd_code != 3'h0);
      st_next.wdir  = 1'b0;
      st_next.ap    = addr_i[sdb_pkg::AP_BIT];
      st_next.bank  = bank_select_i;
      st_next.lcode = rd_code;
      st_next.start = cmd_col;
      st_next.idx   = 11'h001;
      if (rd_code == 3'h0 && addr_i[sdb_pkg::AP_BIT]) begin
        st_next.cls      = 1'b1; // [R1]
        st_next.cls_bank = bank_select_i;
      end
    end

    if (is_wr) begin
      // Read output is dropped at once, whatever the mask
      st_next.p1_v  = 1'b0; // [R8]
      st_next.dq_oe = 1'b0; // [R8]
      if (pend && !st_reg.dqm_d1) begin
        // Mask was low the clock before: the write is refused
        st_next.icnt = st_reg.icnt + 16'h0001; // [R8]
      end else begin
        st_next.maddr = {bank_select_i, cmd_col}; // [R14]
        st_next.mwe   = ~dqm_i; // [R12] [R9]
        st_next.mwd   = dq_i;
        st_next.act   = (wr_code != 3'h0);
        st_next.wdir  = 1'b1;
        st_next.ap    = addr_i[sdb_pkg::AP_BIT];
        st_next.bank  = bank_select_i;
        st_next.lcode = wr_code;
        st_next.start = cmd_col;
        st_next.idx   = 11'h001;
        if (wr_code == 3'h0 && addr_i[sdb_pkg::AP_BIT]) begin
          st_next.cls      = 1'b1;
          st_next.cls_bank = bank_select_i;
        end
      end
    end

    if (st_next.mwe) begin
      st_next.wcnt = st_reg.wcnt + 16'h0001;
    end

    // Register port
    if (reg_wr_i && reg_addr_i == sdb_pkg::REG_MODE) begin
      st_next.mode = reg_wdata_i[sdb_pkg::MODE_W-1:0];
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        sdb_pkg::REG_MODE:   st_next.rdata = {4'h0, st_reg.mode};
        sdb_pkg::REG_STATUS: st_next.rdata = {13'h0000, st_reg.dq_oe,
                                              st_reg.act & st_reg.wdir,
                                              st_reg.act & ~st_reg.wdir};
        sdb_pkg::REG_WCOUNT: st_next.rdata = st_reg.wcnt;
        default:             st_next.rdata = st_reg.icnt;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_reg      <= '0;
      st_reg.mode <= sdb_pkg::MODE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dq_o         = st_reg.dq;
  assign dq_oe_o      = st_reg.dq_oe;
  assign mem_addr_o   = st_reg.maddr;
  assign mem_rd_o     = st_reg.mrd;
  assign mem_we_o     = st_reg.mwe;
  assign mem_wdata_o  = st_reg.mwd;
  assign bank_close_o = st_reg.cls;
  assign close_bank_o = st_reg.cls_bank;
  assign reg_rdata_o  = st_reg.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_rd_lat_two: assert property ( // [R21]
    (is_rd && !cl3 && !dqm_i && !reg_wr_i) ##1 !is_wr |=> dq_oe_o)
    else $error("read data not driven at latency two");

  a_rd_lat_three: assert property ( // [R2]
    (is_rd && cl3 && !reg_wr_i) ##1 (!dqm_i && !is_wr) ##1 !is_wr |=> dq_oe_o)
    else $error("read data not driven at latency three");

  a_out_mask: assert property ( // [R7]
    dqm_i |=> ##1 !dq_oe_o)
    else $error("masked read word was driven");

  a_wr_float: assert property ( // [R8]
    is_wr |=> !dq_oe_o && !st_reg.p1_v)
    else $error("pins driven after truncating write");

  a_wr_capture: assert property ( // [R12]
    is_wr && !dqm_i && !(pend && !st_reg.dqm_d1) |=> mem_we_o && mem_wdata_o == $past(dq_i))
    else $error("write word not captured with command");

  a_rd_stops_wr: assert property ( // [R15]
    is_rd |=> !mem_we_o && mem_rd_o)
    else $error("write continued after read");

  a_bst_ignores: assert property ( // [R19]
    is_bst |=> !mem_we_o && !mem_rd_o)
    else $error("data taken with burst terminate");

  a_idle_float: assert property ( // [R3]
    !st_reg.mrd && !st_reg.p1_v |=> !dq_oe_o)
    else $error("pins driven with no read pending");

  a_wr_single: assert property ( // [R13]
    is_wr && st_reg.mode[sdb_pkg::M_WSGL_BIT] && !reg_wr_i ##1 !is_wr |=> !mem_we_o)
    else $error("single write went on");

  a_col_x32: assert property ( // [R20]
    org == sdb_pkg::ORG_X32 && is_rd && !reg_wr_i |=> mem_addr_o[10:9] == 2'h0)
    else $error("unused column bits reached the array");

  a_seq_step: assert property ( // [R22]
    st_reg.act && !st_reg.wdir && !kill && !st_reg.mode[sdb_pkg::M_TYPE_BIT]
    && st_reg.lcode == 3'h2 |=> mem_addr_o[1:0] == 2'($past(st_reg.start[1:0]
    + st_reg.idx[1:0])))
    else $error("sequential order broken");

  c_rd_chain: cover property (is_rd ##1 is_rd ##1 is_rd);
  c_rd_to_wr: cover property (is_rd ##1 dqm_i[*3] ##1 is_wr);
  c_full_wrap: cover property (st_reg.act && !fixed_len(st_reg.lcode) && col_nxt == 11'h000);
  c_wr_bst: cover property (is_wr ##1 !is_wr ##1 is_bst);

endmodule

/* File: design/sdb_pkg.sv */
package sdb_pkg;

  // ----------------------------------------------------------------
  // Pin field widths and positions
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 13;
  localparam int BANK_W   = 2;
  localparam int COL_W    = 11;
  localparam int AP_BIT   = 10;

  // Command code as {chip select, row strobe, column strobe, write enable}, all low active
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_BST   = 4'h6;

  // ----------------------------------------------------------------
  // Register map (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_MODE   = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_WCOUNT = 2'h2;
  localparam logic [1:0] REG_ICOUNT = 2'h3;

  // Mode register field positions
  localparam int MODE_W      = 12;
  localparam int M_LEN_LSB   = 0;
  localparam int M_TYPE_BIT  = 3;
  localparam int M_CL_LSB    = 4;
  localparam int M_WSGL_BIT  = 9;
  localparam int M_ORG_LSB   = 10;

  // Burst length 4, sequential, latency 2, x16, burst writes
  localparam logic [11:0] MODE_RESET = 12'h422;

  localparam logic [2:0] LEN_MAX_FIXED = 3'h3;
  localparam logic [2:0] CL_THREE      = 3'h3;

  // Organisation codes
  localparam logic [1:0] ORG_X32 = 2'h0;
  localparam logic [1:0] ORG_X16 = 2'h1;
  localparam logic [1:0] ORG_X8  = 2'h2;

  // Page masks per organisation
  localparam logic [10:0] PAGE_X32 = 11'h1FF;
  localparam logic [10:0] PAGE_X16 = 11'h3FF;
  localparam logic [10:0] PAGE_X8  = 11'h7FF;

  localparam int CNT_W = 16;

endpackage

/* File: design/sdb_col_gen.sv */
`timescale 1ns/1ps
module sdb_col_gen #(
  parameter int COL_W = 11
) (
  input  wire logic [COL_W-1:0] start_i,
  input  wire logic [COL_W-1:0] idx_i,
  input  wire logic [COL_W-1:0] blk_i,
  input  wire logic             il_i,
  output logic      [COL_W-1:0] col_o
);

  // ----------------------------------------------------------------
  // Burst column order
  // ----------------------------------------------------------------
  // Upper bits stay fixed so the burst wraps inside its aligned block
  logic [COL_W-1:0] step;

  always_comb begin
    step  = il_i ? (start_i ^ idx_i) : COL_W'(start_i + idx_i);
    col_o = (start_i & ~blk_i) | (step & blk_i);
  end

endmodule

/* File: bench/sdb_store_model.sv */
`timescale 1ns/1ps
// Storage array behind the engine; reads answer in the same cycle
module sdb_store_model (
  input  wire logic        clk_sys_i,
  input  wire logic [14:0] addr_i,
  input  wire logic        we_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o
);
  logic [31:0] arr [0:32767];

  initial begin
    for (int i = 0; i < 32768; i++) begin
      arr[i] = 32'h5A00_0000 | i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      arr[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = arr[addr_i];
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  cmd = 4'h7;
  logic [1:0]  bank_select_i = 2'h0;
  logic [12:0] addr_i = 13'h0000;
  logic        dqm_i = 1'b0;
  logic [31:0] dq_i = 32'h0000_0000;
  logic [1:0]  reg_addr_i = 2'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        rd_d = 1'b0;
  logic [31:0] dq_o, mem_wdata_o, mem_rdata_i;
  logic        dq_oe_o, mem_rd_o, mem_we_o, bank_close_o, il;
  logic [14:0] mem_addr_o;
  logic [1:0]  close_bank_o, org, wb, b;
  logic [15:0] reg_rdata_o;
  logic [10:0] wc;
  logic [12:0] a;
  int          n_fail = 0, checked = 0, ecnt = 0, blen, cl, tv, wk;
  logic [31:0] qd[$], qwd[$], shadow[int];
  logic [14:0] qwa[$];
  logic [15:0] qr[$];
  logic [1:0]  qc[$];
  int          qt[$], qwt[$];

  sdb_burst_engine u_sdb_burst_engine (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]),
    .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_select_i(bank_select_i), .addr_i(addr_i),
    .dqm_i(dqm_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .bank_close_o(bank_close_o), .close_bank_o(close_bank_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

  sdb_store_model u_sdb_store_model (.clk_sys_i(clk_sys_i), .addr_i(mem_addr_o),
    .we_i(mem_we_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------------------------------
  // Expected column order and array contents
  // ----------------------------------------------------------------
  function automatic logic [10:0] ecol(input logic [10:0] s, input int k);
    logic [10:0] m;
    m = (blen > 8) ? (org == 2'h0 ? sdb_pkg::PAGE_X32 : org == 2'h1 ? sdb_pkg::PAGE_X16
                                  : sdb_pkg::PAGE_X8) : 11'(blen - 1);
    if (il && blen <= 8) return (s & ~m) | ((s ^ 11'(k)) & m);
    return (s & ~m) | ((s + 11'(k)) & m);
  endfunction

  function automatic logic [10:0] scol(input logic [12:0] x);
    return org == 2'h0 ? {2'h0, x[8:0]} : org == 2'h1 ? {1'b0, x[9:0]} : {x[11], x[9:0]};
  endfunction

  function automatic logic [31:0] mval(input logic [14:0] x);
    return shadow.exists(int'(x)) ? shadow[int'(x)] : (32'h5A00_0000 | 32'(x));
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Drivers; each call but done and wrap_up owns one clock cycle and notes its results
  // ----------------------------------------------------------------
  // Every input is assigned once per cycle; fix[0] pins bank and address, fix[1] the data
  task automatic cyc(input logic [3:0] c = 4'h7, input logic m = 1'b0,
                     input logic [1:0] fix = 2'b00, input logic [1:0] bk = 2'h0,
                     input logic [12:0] ad = 13'h0000, input logic [31:0] d = 32'h0,
                     input logic [1:0] rq = 2'b00, input logic [1:0] ri = 2'h0,
                     input logic [15:0] rv = 16'h0000);
    @(posedge clk_sys_i);
    tv = ecnt;
    cmd <= c;
    dqm_i <= m;
    dq_i <= fix[1] ? d : $urandom;
    reg_wr_i <= rq[0];
    reg_rd_i <= rq[1];
    reg_addr_i <= ri;
    reg_wdata_i <= rv;
    bank_select_i <= fix[0] ? bk : 2'($urandom);
    addr_i <= fix[0] ? ad : 13'($urandom);
  endtask

  task automatic cmdb(input logic [3:0] c, input logic [1:0] bk, input logic [12:0] ad);
    cyc(c, 1'b0, 2'b01, bk, ad);
  endtask

  task automatic rd(input logic [1:0] bk, input logic [12:0] ad, input int n);
    cmdb(sdb_pkg::CMD_READ, bk, ad);
    for (int k = 0; k < n; k++) begin
      qd.push_back(mval({bk, ecol(scol(ad), k)}));
      qt.push_back(tv + 1 + cl + k);
    end
    if (ad[10]) qc.push_back(bk);
  endtask

  // Write command when c is a write, otherwise a data beat of the open burst
  task automatic wr(input logic [3:0] c, input logic [1:0] bk, input logic [12:0] ad,
                    input logic m);
    logic [31:0] d;
    d = $urandom;
    if (c == sdb_pkg::CMD_WRITE) begin
      cyc(c, m, 2'b11, bk, ad, d);
      wb = bk;
      wc = scol(ad);
      wk = 0;
    end else begin
      cyc(c, m, 2'b10, 2'h0, 13'h0000, d);
      wk++;
    end
    if (!m) begin
      qwa.push_back({wb, ecol(wc, wk)});
      qwd.push_back(d);
      qwt.push_back(tv + 2);
      shadow[int'({wb, ecol(wc, wk)})] = d;
    end
  endtask

  task automatic rg(input logic w, input logic [1:0] i, input logic [15:0] v);
    cyc(4'h7, 1'b0, 2'b00, 2'h0, 13'h0000, 32'h0, w ? 2'b01 : 2'b10, i, v);
    if (!w) qr.push_back(v);
  endtask

  task automatic md(input int lc, input logic t, input int c, input logic [1:0] o);
    rg(1'b1, sdb_pkg::REG_MODE, 16'({o, 3'h0, 3'(c), t, 3'(lc)}));
    blen = lc >= 4 ? 2048 : 1 << lc;
    il = t;
    cl = c;
    org = o;
  endtask

  task automatic done(input string s);
    // Long enough for a burst of eight at latency three to drain
    repeat (12) cyc();
    $display("test %s finished", s);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Output watcher: takes the oldest note whenever a result shows
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    ecnt <= ecnt + 1;
    rd_d <= reg_rd_i;
    if (rst_n_i) begin
      if (rd_d) chk({16'h0, reg_rdata_o}, {16'h0, qr.pop_front()});
      if (dq_oe_o !== 1'b0) begin
        if (qd.size() == 0) chk(32'h1, 32'h0);
        else begin
          chk(dq_o, qd.pop_front());
          chk(ecnt, qt.pop_front());
        end
      end
      if (mem_we_o !== 1'b0) begin
        if (qwa.size() == 0) chk(32'h1, 32'h0);
        else begin
          chk({17'h0, mem_addr_o}, {17'h0, qwa.pop_front()});
          chk(mem_wdata_o, qwd.pop_front());
          chk(ecnt, qwt.pop_front());
        end
      end
      if (bank_close_o !== 1'b0) begin
        if (qc.size() == 0) chk(32'h1, 32'h0);
        else chk({30'h0, close_bank_o}, {30'h0, qc.pop_front()});
      end
    end
  end

  initial begin
    repeat (6000) @(posedge clk_sys_i);
    n_fail++;
    wrap_up();
  end

  initial begin
    tv = $urandom(32'h3b7e);
    blen = 4;
    cl = 2;
    il = 1'b0;
    org = 2'h1;
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rg(1'b0, sdb_pkg::REG_MODE, 16'(sdb_pkg::MODE_RESET));
    rg(1'b1, sdb_pkg::REG_STATUS, 16'hFFFF);
    rg(1'b0, sdb_pkg::REG_STATUS, 16'h0000);
    done("registers");
    rd(2'h0, 13'h0001, 1);
    rd(2'h3, 13'h0006, 4);
    done("back_to_back_reads");
    md(7, 1'b0, 3, 2'h1);
    rd(2'h1, 13'h03FE, 4);
    repeat (3) cyc();
    cyc(sdb_pkg::CMD_BST);
    done("page_wrap_terminate");
    md(3, 1'b0, 2, 2'h1);
    rd(2'h2, 13'h000D, 2);
    cyc();
    cmdb(sdb_pkg::CMD_PRE, 2'h2, 13'h0000);
    done("read_precharge");
    rd(2'h0, 13'h0010, 3);
    repeat (2) cyc();
    repeat (3) cyc(4'h7, 1'b1);
    wr(sdb_pkg::CMD_WRITE, 2'h0, 13'h0020, 1'b0);
    repeat (7) wr(4'h7, 2'h0, 13'h0, 1'b0);
    done("read_truncated_by_write");
    md(2, 1'b0, 2, 2'h1);
    wr(sdb_pkg::CMD_WRITE, 2'h1, 13'h0040, 1'b0);
    wr(4'h7, 2'h0, 13'h0, 1'b1);
    wr(sdb_pkg::CMD_WRITE, 2'h1, 13'h0045, 1'b0);
    repeat (3) wr(4'h7, 2'h0, 13'h0, 1'b0);
    cyc();
    wr(sdb_pkg::CMD_WRITE, 2'h2, 13'h0048, 1'b0);
    wr(4'h7, 2'h0, 13'h0, 1'b0);
    rd(2'h2, 13'h0048, 4);
    repeat (5) cyc();
    wr(sdb_pkg::CMD_WRITE, 2'h3, 13'h0050, 1'b0);
    wr(4'h7, 2'h0, 13'h0, 1'b0);
    cyc(sdb_pkg::CMD_BST);
    repeat (4) cyc();
    rd(2'h3, 13'h0050, 4);
    repeat (5) cyc();
    wr(sdb_pkg::CMD_WRITE, 2'h1, 13'h0070, 1'b0);
    wr(4'h7, 2'h0, 13'h0, 1'b1);
    cyc(sdb_pkg::CMD_PRE, 1'b1, 2'b01, 2'h1, 13'h0000);
    repeat (4) cyc();
    done("write_truncation");
    rg(1'b1, sdb_pkg::REG_MODE, 16'h0622);
    wr(sdb_pkg::CMD_WRITE, 2'h0, 13'h0060, 1'b0);
    cyc();
    done("single_write");
    repeat (12) begin
      md($urandom_range(3), 1'($urandom), $urandom_range(3, 2), 2'($urandom_range(2)));
      b = 2'($urandom);
      a = 13'($urandom);
      wr(sdb_pkg::CMD_WRITE, b, a & 13'h1BFF, 1'b0);
      repeat (blen - 1) wr(4'h7, 2'h0, 13'h0, 1'($urandom));
      repeat (4) cyc();
      rd(b, a, blen);
      done("random_burst");
    end
    chk(32'(qd.size() + qwa.size() + qc.size()), 32'h0);
    wrap_up();
  end
endmodule
